/* logic/tsp_pkg.sv */
// Shared constants and types for the scan path controller and the tester end.
// Assumes both ends run on SYS_CLK; the scan clock is sampled, never used as a clock.
// Operation
// - Boundary capture only under external-test or sample
// - Data capture: TMS high exit1, low shift
// - Data shift moves selected register one stage
// - Data shift: stay on low, exit1 on high
// - Data exit1: high update, low pause
// - Data pause holds; high goes to exit2
// - Data exit2: high update, low shift
// - Boundary latch updates on falling edge only
// - Data stages other than the self-test bit hold outside capture and shift
// - Active instruction fixed during scan states
// - IR select: low capture, high reset
// - Instruction capture loads pattern 0001
// - IR capture: high exit1, low shift
// - IR shift moves instruction register one stage
// - IR shift: stay on low, exit1 on high
// - IR exit1: high update, low pause
// - IR pause holds; high goes to exit2
// - IR exit2: high update, low shift
// - IR update on falling edge becomes active
// - Five high TMS edges reach reset, identification
// - State changes only on rising edge, reset
package tsp_pkg;

  // ********************************************************************
  // Controller states and register select
  // ********************************************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tsp_state_type;

  typedef enum logic [2:0] {SEL_BND, SEL_ID, SEL_BYP, SEL_BIST, SEL_ZERO} tsp_sel_type;

  // ********************************************************************
  // Widths, codes, capture values
  // ********************************************************************
  localparam int IR_LEN = 4;
  localparam int BND_LEN = 107;
  localparam int ID_LEN = 32;
  localparam logic [3:0] OP_EXTERNAL = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDENT = 4'h2;
  localparam logic [3:0] OP_SELFTEST = 4'h8;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = OP_IDENT;
  // Identification word: arbitrary value, low bit set as required
  localparam logic [31:0] ID_WORD = 32'h0abc_d001;

  // ********************************************************************
  // Tester timing
  // ********************************************************************
  localparam int SYS_CLK_NS = 4;
  localparam int TCK_HALF_NS = 64;
  localparam int TCK_HALF_CYC = TCK_HALF_NS / SYS_CLK_NS;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 2;

endpackage

/* logic/tsp_link_if.sv */
// Scan link between the tester end and the device end.
// Assumes both ends share SYS_CLK; TDO level is worked out here from its enable.
`timescale 1ns/100ps
interface tsp_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_wire;

  // Undriven TDO reads high, as a pull-up would make it
  assign tdo_wire = tdo_oe ? tdo : 1'b1;

  modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
  modport tst (output tck, output tms, output tdi, input tdo_wire);
endinterface

/* logic/tsp_scan_dev.sv */
// Device end: scan state machine, instruction register and data registers.
// Assumes TCK, TMS and TDI arrive asynchronously; all three pass two flops.
`timescale 1ns/100ps
module tsp_scan_dev (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  tsp_link_if.dev JTAG,
  input wire logic [tsp_pkg::BND_LEN-1:0] BND_PIN_IN,
  output logic [tsp_pkg::BND_LEN-1:0] BND_PIN_OUT,
  output logic [tsp_pkg::IR_LEN-1:0] ACTIVE_IR,
  output tsp_pkg::tsp_state_type TAP_STATE,
  output logic SELFTEST_RUN,
  input wire logic SELFTEST_DONE,
  input wire logic SELFTEST_FAIL
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic tck_s1;
    logic tck_s2;
    logic tck_s3;
    logic tms_s1;
    logic tms_s2;
    logic tdi_s1;
    logic tdi_s2;
    tsp_pkg::tsp_state_type state;
    logic [tsp_pkg::IR_LEN-1:0] ir_sh;
    logic [tsp_pkg::IR_LEN-1:0] ir;
    logic [tsp_pkg::BND_LEN-1:0] bnd_sh;
    logic [tsp_pkg::BND_LEN-1:0] bnd_out;
    logic [tsp_pkg::ID_LEN-1:0] id_sh;
    logic byp;
    logic bist;
    logic bist_run;
    logic tdo;
    logic tdo_oe;
  } tsp_dev_st_type;

  localparam tsp_dev_st_type DEV_RST = '{
    tck_s1: 1'b0, tck_s2: 1'b0, tck_s3: 1'b0, tms_s1: 1'b1, tms_s2: 1'b1,
    tdi_s1: 1'b1, tdi_s2: 1'b1, state: tsp_pkg::TLR, ir_sh: '0,
    ir: tsp_pkg::IR_RESET, bnd_sh: '0, bnd_out: '0, id_sh: '0, byp: 1'b0,
    bist: 1'b0, bist_run: 1'b0, tdo: 1'b1, tdo_oe: 1'b0};

  tsp_dev_st_type st_r;
  tsp_dev_st_type st_nxt;
  logic tck_rise;
  logic tck_fall;
  tsp_pkg::tsp_sel_type sel;
  logic sel_bit;

  // ********************************************************************
  // Next state from TMS at a rising edge
  // ********************************************************************
  function automatic tsp_pkg::tsp_state_type step(input tsp_pkg::tsp_state_type s,
                                                  input logic tms);
    case (s)
      tsp_pkg::TLR: step = tms ? tsp_pkg::TLR : tsp_pkg::RTI;
      tsp_pkg::RTI: step = tms ? tsp_pkg::SEL_DR : tsp_pkg::RTI;
      tsp_pkg::SEL_DR: step = tms ? tsp_pkg::SEL_IR : tsp_pkg::CAP_DR;
      tsp_pkg::CAP_DR: step = tms ? tsp_pkg::EX1_DR : tsp_pkg::SHF_DR;
      tsp_pkg::SHF_DR: step = tms ? tsp_pkg::EX1_DR : tsp_pkg::SHF_DR;
      tsp_pkg::EX1_DR: step = tms ? tsp_pkg::UPD_DR : tsp_pkg::PAU_DR;
      tsp_pkg::PAU_DR: step = tms ? tsp_pkg::EX2_DR : tsp_pkg::PAU_DR;
      tsp_pkg::EX2_DR: step = tms ? tsp_pkg::UPD_DR : tsp_pkg::SHF_DR;
      tsp_pkg::UPD_DR: step = tms ? tsp_pkg::SEL_DR : tsp_pkg::RTI;
      tsp_pkg::SEL_IR: step = tms ? tsp_pkg::TLR : tsp_pkg::CAP_IR;
      tsp_pkg::CAP_IR: step = tms ? tsp_pkg::EX1_IR : tsp_pkg::SHF_IR;
      tsp_pkg::SHF_IR: step = tms ? tsp_pkg::EX1_IR : tsp_pkg::SHF_IR;
      tsp_pkg::EX1_IR: step = tms ? tsp_pkg::UPD_IR : tsp_pkg::PAU_IR;
      tsp_pkg::PAU_IR: step = tms ? tsp_pkg::EX2_IR : tsp_pkg::PAU_IR;
      tsp_pkg::EX2_IR: step = tms ? tsp_pkg::UPD_IR : tsp_pkg::SHF_IR;
      tsp_pkg::UPD_IR: step = tms ? tsp_pkg::SEL_DR : tsp_pkg::RTI;
      default: step = tsp_pkg::TLR;
    endcase
  endfunction

  // ********************************************************************
  // Register select from the active instruction
  // ********************************************************************
  // Unlisted codes shift zeros, so a stray code cannot disturb the core
  always_comb begin
    case (st_r.ir)
      tsp_pkg::OP_EXTERNAL, tsp_pkg::OP_SAMPLE: sel = tsp_pkg::SEL_BND;
      tsp_pkg::OP_IDENT: sel = tsp_pkg::SEL_ID;
      tsp_pkg::OP_SELFTEST: sel = tsp_pkg::SEL_BIST;
      tsp_pkg::OP_BYPASS: sel = tsp_pkg::SEL_BYP;
      default: sel = tsp_pkg::SEL_ZERO;
    endcase
  end

  // Serial output bit of the selected data register
  always_comb begin
    case (sel)
      tsp_pkg::SEL_BND: sel_bit = st_r.bnd_sh[0];
      tsp_pkg::SEL_ID: sel_bit = st_r.id_sh[0];
      tsp_pkg::SEL_BYP: sel_bit = st_r.byp;
      tsp_pkg::SEL_BIST: sel_bit = st_r.bist;
      default: sel_bit = 1'b0;
    endcase
  end

  // Edges come from the second and third flops, never the first
  assign tck_rise = st_r.tck_s2 & ~st_r.tck_s3;
  assign tck_fall = ~st_r.tck_s2 & st_r.tck_s3;

  // ********************************************************************
  // Next value of all state
  // ********************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.tck_s1 = JTAG.tck;
    st_nxt.tck_s2 = st_r.tck_s1;
    st_nxt.tck_s3 = st_r.tck_s2;
    st_nxt.tms_s1 = JTAG.tms;
    st_nxt.tms_s2 = st_r.tms_s1;
    st_nxt.tdi_s1 = JTAG.tdi;
    st_nxt.tdi_s2 = st_r.tdi_s1;
    // Rising edge: move state, capture and shift, load the self-test run flag in idle; other states hold
    if (tck_rise) begin
      st_nxt.state = step(st_r.state, st_r.tms_s2);
      case (st_r.state)
        tsp_pkg::CAP_DR: begin
          case (sel)
            tsp_pkg::SEL_BND: st_nxt.bnd_sh = BND_PIN_IN;
            tsp_pkg::SEL_ID: st_nxt.id_sh = tsp_pkg::ID_WORD;
            tsp_pkg::SEL_BYP: st_nxt.byp = 1'b0;
            default: ;
          endcase
        end
        tsp_pkg::SHF_DR: begin
          case (sel)
            tsp_pkg::SEL_BND: st_nxt.bnd_sh = {st_r.tdi_s2, st_r.bnd_sh[tsp_pkg::BND_LEN-1:1]};
            tsp_pkg::SEL_ID: st_nxt.id_sh = {st_r.tdi_s2, st_r.id_sh[tsp_pkg::ID_LEN-1:1]};
            tsp_pkg::SEL_BYP: st_nxt.byp = st_r.tdi_s2;
            tsp_pkg::SEL_BIST: st_nxt.bist = st_r.tdi_s2;
            default: ;
          endcase
        end
        tsp_pkg::CAP_IR: st_nxt.ir_sh = tsp_pkg::IR_CAPTURE;
        tsp_pkg::SHF_IR: st_nxt.ir_sh = {st_r.tdi_s2, st_r.ir_sh[tsp_pkg::IR_LEN-1:1]};
        tsp_pkg::RTI: st_nxt.bist_run = (sel == tsp_pkg::SEL_BIST);
        default: ;
      endcase
    end
    // Falling edge: updates and TDO; the instruction moves only here or in the reset state
    if (tck_fall) begin
      case (st_r.state)
        tsp_pkg::UPD_IR: begin
          st_nxt.ir = st_r.ir_sh;
          st_nxt.bist = (st_r.ir_sh == tsp_pkg::OP_SELFTEST);
        end
        tsp_pkg::UPD_DR: begin
          if (sel == tsp_pkg::SEL_BND) begin
            st_nxt.bnd_out = st_r.bnd_sh;
          end
        end
        default: ;
      endcase
      st_nxt.tdo_oe = (st_r.state == tsp_pkg::SHF_DR) || (st_r.state == tsp_pkg::SHF_IR);
      if (st_r.state == tsp_pkg::SHF_IR) begin
        st_nxt.tdo = st_r.ir_sh[0];
      end else if (st_r.state == tsp_pkg::SHF_DR) begin
        st_nxt.tdo = sel_bit;
      end
    end
    // Self-test stand-in: result lands in the one-bit register, 0 is a pass
    if (st_r.bist_run && SELFTEST_DONE) begin
      st_nxt.bist = SELFTEST_FAIL;
      st_nxt.bist_run = 1'b0;
    end
    if (st_r.state != tsp_pkg::RTI || sel != tsp_pkg::SEL_BIST) begin
      st_nxt.bist_run = 1'b0;
    end
    // Reset state forces the identification instruction
    if (st_r.state == tsp_pkg::TLR) begin
      st_nxt.ir = tsp_pkg::IR_RESET;
      st_nxt.bist_run = 1'b0;
    end
  end

  // Synchronous reset stands in for power-up
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_r <= DEV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************************
  // Outputs, all from flops
  // ********************************************************************
  assign JTAG.tdo = st_r.tdo;
  assign JTAG.tdo_oe = st_r.tdo_oe;
  assign BND_PIN_OUT = st_r.bnd_out;
  assign ACTIVE_IR = st_r.ir;
  assign TAP_STATE = st_r.state;
  assign SELFTEST_RUN = st_r.bist_run;

endmodule // tsp_scan_dev

/* logic/tsp_scan_tst.sv */
// Tester end: a command FIFO feeding a TCK divider that drives TMS and TDI.
// Assumes TDO comes from another block; it passes two flops before use.
`timescale 1ns/100ps
module tsp_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [WIDTH-1:0] IN_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [WIDTH-1:0] OUT_DATA
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tsp_fifo_st_type;

  tsp_fifo_st_type st_r;
  tsp_fifo_st_type st_nxt;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign IN_READY = (st_r.cnt != (AW+1)'(DEPTH));
  assign OUT_VALID = (st_r.cnt != '0);
  assign OUT_DATA = st_r.mem[st_r.rp];
  assign push = IN_VALID & IN_READY;
  assign pop = OUT_VALID & OUT_READY;

  // Pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = IN_DATA;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // tsp_fifo

module tsp_scan_tst (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  tsp_link_if.tst JTAG,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_TMS,
  input wire logic CMD_TDI,
  output logic RSP_VALID,
  output logic RSP_TDO
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic [1:0] {T_IDLE, T_LOW, T_HIGH} tsp_tst_ph_type;

  typedef struct packed {
    tsp_tst_ph_type ph;
    logic [4:0] cnt;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_s1;
    logic tdo_s2;
    logic rsp_v;
    logic rsp_d;
  } tsp_tst_st_type;

  localparam logic [4:0] HALF = 5'(tsp_pkg::TCK_HALF_CYC - 1);

  tsp_tst_st_type st_r;
  tsp_tst_st_type st_nxt;
  logic q_valid;
  logic q_ready;
  logic [1:0] q_data;

  // Commands wait here; the drain stalls for a whole TCK period each
  tsp_fifo #(.WIDTH(tsp_pkg::FIFO_WIDTH), .DEPTH(tsp_pkg::FIFO_DEPTH)) u_fifo (
    .SYS_CLK(SYS_CLK),
    .RST_N(RST_N),
    .IN_VALID(CMD_VALID),
    .IN_READY(CMD_READY),
    .IN_DATA({CMD_TMS, CMD_TDI}),
    .OUT_VALID(q_valid),
    .OUT_READY(q_ready),
    .OUT_DATA(q_data)
  );

  assign q_ready = (st_r.ph == T_IDLE);

  // ********************************************************************
  // One TCK period per command; TMS/TDI change only while TCK is low
  // ********************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.tdo_s1 = JTAG.tdo_wire;
    st_nxt.tdo_s2 = st_r.tdo_s1;
    st_nxt.rsp_v = 1'b0;
    case (st_r.ph)
      T_IDLE: begin
        if (q_valid) begin
          st_nxt.tms = q_data[1];
          st_nxt.tdi = q_data[0];
          st_nxt.cnt = HALF;
          st_nxt.ph = T_LOW;
        end
      end
      T_LOW: begin
        if (st_r.cnt == '0) begin
          st_nxt.tck = 1'b1;
          st_nxt.rsp_d = st_r.tdo_s2;
          st_nxt.cnt = HALF;
          st_nxt.ph = T_HIGH;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      T_HIGH: begin
        if (st_r.cnt == '0) begin
          st_nxt.tck = 1'b0;
          st_nxt.rsp_v = 1'b1;
          st_nxt.ph = T_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      default: st_nxt.ph = T_IDLE;
    endcase
  end

  // TMS idles high so a fresh link stays in its reset state
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_r <= '{ph: T_IDLE, cnt: 5'h00, tck: 1'b0, tms: 1'b1, tdi: 1'b1,
                tdo_s1: 1'b1, tdo_s2: 1'b1, rsp_v: 1'b0, rsp_d: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign JTAG.tck = st_r.tck;
  assign JTAG.tms = st_r.tms;
  assign JTAG.tdi = st_r.tdi;
  assign RSP_VALID = st_r.rsp_v;
  assign RSP_TDO = st_r.rsp_d;

endmodule // tsp_scan_tst

/* tb/tsp_link_properties.sv */
// Checker: timing relations on the scan link wires.
// Assumes it sits beside the link interface and runs in the SYS_CLK domain.
`timescale 1ns/100ps
module tsp_link_properties (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tdo_wire
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;

  // ********************************************************************
  // Run lengths of TCK high and low
  // ********************************************************************
  // Saturating, so a long idle gap cannot wrap into a false short phase
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
    end else begin
      hi_cnt <= tck ? hi_cnt + {7'h00, hi_cnt != 8'hff} : 8'h00;
      lo_cnt <= tck ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
    end
  end

  // Mode and data must not move around the sampling edge
  property p_tms_stable; tck |-> $stable(tms); endproperty
  a_tms_stable: assert property (p_tms_stable) else $error("tms moved, tck high");
  property p_tdi_stable; tck |-> $stable(tdi); endproperty
  a_tdi_stable: assert property (p_tdi_stable) else $error("tdi moved, tck high");
  // Divider phases: high one half period or one cycle more, low at least one
  property p_tck_high;
    $fell(tck) |-> int'(hi_cnt) inside {[tsp_pkg::TCK_HALF_CYC:tsp_pkg::TCK_HALF_CYC + 1]};
  endproperty
  a_tck_high: assert property (p_tck_high) else $error("tck high phase length");
  property p_tck_low; $rose(tck) |-> int'(lo_cnt) >= tsp_pkg::TCK_HALF_CYC; endproperty
  a_tck_low: assert property (p_tck_low) else $error("tck low phase too short");
  // Serial output moves only shortly after a falling TCK
  property p_oe_change; $changed(tdo_oe) |-> !tck && lo_cnt inside {[1:8]}; endproperty
  a_oe_change: assert property (p_oe_change) else $error("tdo_oe moved off fall");
  property p_tdo_change; $changed(tdo) |-> !tck && lo_cnt inside {[1:8]}; endproperty
  a_tdo_change: assert property (p_tdo_change) else $error("tdo moved off fall");
  property p_oe_hold; $rose(tdo_oe) |-> tdo_oe [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("tdo_oe glitch");
  property p_pullup; !tdo_oe |-> tdo_wire; endproperty
  a_pullup: assert property (p_pullup) else $error("released tdo not high");
endmodule // tsp_link_properties

/* tb/testbench.sv */
// Bench: tester end drives device end over the link; scans judged at user ports.
// Assumes tsp_pkg compiled first; self-test inputs are held idle except in the self-test scenario.
`timescale 1ns/100ps
module testbench;
  logic sys_clk;
  logic rst_n;
  logic cmd_valid;
  logic cmd_ready;
  logic cmd_tms;
  logic cmd_tdi;
  logic rsp_valid;
  logic rsp_tdo;
  logic [tsp_pkg::BND_LEN-1:0] pins;
  logic [tsp_pkg::BND_LEN-1:0] bnd_out;
  logic [3:0] act_ir;
  tsp_pkg::tsp_state_type state;
  logic st_run;
  logic st_done;
  logic st_fail;
  int fails;
  int n_compared;
  int cyc;
  int stalls;
  logic rsp_q[$];
  tsp_link_if link ();

  tsp_scan_tst u_tsp_scan_tst (.SYS_CLK(sys_clk), .RST_N(rst_n), .JTAG(link.tst),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_TMS(cmd_tms), .CMD_TDI(cmd_tdi),
    .RSP_VALID(rsp_valid), .RSP_TDO(rsp_tdo));
  tsp_scan_dev u_tsp_scan_dev (.SYS_CLK(sys_clk), .RST_N(rst_n), .JTAG(link.dev),
    .BND_PIN_IN(pins), .BND_PIN_OUT(bnd_out), .ACTIVE_IR(act_ir), .TAP_STATE(state),
    .SELFTEST_RUN(st_run), .SELFTEST_DONE(st_done), .SELFTEST_FAIL(st_fail));
  tsp_link_properties u_tsp_link_properties (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe),
    .tdo_wire(link.tdo_wire));

  // ********************************************************************
  // Clock, response capture, hang guard
  // ********************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Responses queued in order; stalls prove the FIFO refused
  always @(posedge sys_clk) begin
    if (rsp_valid === 1'b1)
      rsp_q.push_back(rsp_tdo);
    if (cmd_valid === 1'b1 && cmd_ready === 1'b0)
      stalls++;
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One command per TCK period, bit i of each vector; waits for every response
  task automatic scan(input logic [127:0] tms, input logic [127:0] tdi, input int n,
                      output logic [127:0] got);
    int k;
    got = 128'h0;
    rsp_q.delete();
    for (int i = 0; i < n; i++) begin
      cmd_valid <= 1'b1;
      cmd_tms <= tms[i];
      cmd_tdi <= tdi[i];
      do @(negedge sys_clk); while (cmd_ready !== 1'b1);
      @(posedge sys_clk);
    end
    cmd_valid <= 1'b0;
    for (k = 0; k < 5000 && rsp_q.size() < n; k++) @(posedge sys_clk);
    // A missing response is a hang of the link, not a silent zero
    check("responses", 128'(rsp_q.size()), 128'(n));
    foreach (rsp_q[i]) got[i] = rsp_q[i];
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  // Instruction load, straight or through pause and second exit
  task automatic load_ir(input logic [3:0] code, input logic pause);
    logic [127:0] got;
    if (pause) begin
      scan(128'h3486, {115'h0, code[3], 4'h0, code[2:0], 5'h00}, 15, got);
      check("ir capture", 128'(got[12:5]), 128'h79);
    end else begin
      scan(128'h306, {119'h0, code, 5'h00}, 11, got);
      check("ir capture", 128'(got[8:5]), 128'h1);
    end
    check("active ir", 128'(act_ir), 128'(code));
    check("state", 128'(state), 128'(tsp_pkg::RTI));
  endtask

  task automatic t_idcode();
    logic [127:0] got;
    check("reset state", 128'(state), 128'(tsp_pkg::TLR));
    check("reset ir", 128'(act_ir), 128'(tsp_pkg::IR_RESET));
    check("idle tdo", 128'(link.tdo_wire), 128'h1);
    scan(128'h2 | (128'h3 << 35), 128'h0, 38, got);
    check("id word", 128'(got[35:4]), 128'(tsp_pkg::ID_WORD));
    check("ir kept", 128'(act_ir), 128'(tsp_pkg::OP_IDENT));
    $display("test idcode done");
  endtask

  // Both capturing codes; latch must only follow the update state
  task automatic t_boundary();
    logic [127:0] got;
    logic [127:0] pat;
    logic [106:0] pv;
    logic [106:0] last;
    pat = {4{32'hc3a5_0f96}};
    last = 107'h0;
    for (int j = 0; j < 2; j++) begin
      pv = pat[106:0] ^ {107{j[0]}};
      pins <= pv;
      load_ir(j ? tsp_pkg::OP_EXTERNAL : tsp_pkg::OP_SAMPLE, 1'b0);
      check("latch held", 128'(bnd_out), 128'(last));
      scan(128'h1 | (128'h3 << 109), {18'h0, ~pv, 3'h0}, 112, got);
      last = ~pv;
      check("pins captured", 128'(got[109:3]), 128'(pv));
      check("latch updated", 128'(bnd_out), 128'(last));
    end
    $display("test boundary done");
  endtask

  // Bypass bit held across pause and exits
  task automatic t_bypass();
    logic [127:0] got;
    load_ir(tsp_pkg::OP_BYPASS, 1'b1);
    scan(128'hd21, 128'h08, 13, got);
    check("bypass path", 128'(got[10:3]), 128'h7a);
    check("state", 128'(state), 128'(tsp_pkg::RTI));
    check("latch kept", 128'(bnd_out), {21'h0, 107'({4{32'hc3a5_0f96}})});
    check("ir kept", 128'(act_ir), 128'(tsp_pkg::OP_BYPASS));
    $display("test bypass done");
  endtask

  // Twenty high commands back to back: fills FIFO, forces reset state
  task automatic t_tms_reset();
    logic [127:0] got;
    stalls = 0;
    scan(128'hf_ffff, 128'h0, 20, got);
    check("fifo refused", 128'(stalls > 0), 128'h1);
    check("state", 128'(state), 128'(tsp_pkg::TLR));
    check("ir reset", 128'(act_ir), 128'(tsp_pkg::IR_RESET));
    load_ir(tsp_pkg::OP_EXTERNAL, 1'b0);
    scan(128'h7, 128'h0, 3, got);
    check("sel ir exit", 128'(state), 128'(tsp_pkg::TLR));
    check("ir reset", 128'(act_ir), 128'(tsp_pkg::IR_RESET));
    $display("test tms reset done");
  endtask

  // Self-test code: run flag in idle, done pulse, result read back
  task automatic t_selftest();
    logic [127:0] got;
    load_ir(tsp_pkg::OP_SELFTEST, 1'b0);
    scan(128'h0, 128'h0, 1, got);
    check("selftest run", 128'(st_run), 128'h1);
    st_fail <= 1'b0;
    st_done <= 1'b1;
    @(posedge sys_clk);
    st_done <= 1'b0;
    @(posedge sys_clk);
    check("selftest stop", 128'(st_run), 128'h0);
    scan(128'h19, 128'h0, 6, got);
    check("selftest result", 128'(got[3]), 128'h0);
    check("state", 128'(state), 128'(tsp_pkg::RTI));
    $display("test selftest done");
  endtask

  // Capture straight to exit on both paths, then pause, second exit, update
  task automatic t_direct_update();
    logic [127:0] got;
    pins <= 107'({4{32'h5a3c_e187}});
    scan(128'h35d6, 128'h0, 15, got);
    check("no tdo drive", 128'(got[14:0]), 128'h7fff);
    check("ir captured", 128'(act_ir), 128'(tsp_pkg::IR_CAPTURE));
    check("latch direct", 128'(bnd_out), 128'(pins));
    check("state", 128'(state), 128'(tsp_pkg::RTI));
    $display("test direct update done");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_tms = 1'b0;
    cmd_tdi = 1'b0;
    pins = 107'h0;
    st_done = 1'b0;
    st_fail = 1'b0;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    stalls = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_idcode();
    t_boundary();
    t_bypass();
    t_selftest();
    t_tms_reset();
    t_direct_update();
    end_sim();
  end
endmodule // testbench
